// File: src/cfao_pkg.sv
// Purpose: shared constants and carriers for the control-flow and address instruction unit
// Assumes: 16-bit operation words, 32-bit addresses, eight address registers
// Notes: address register 7 is the stack pointer
package cfao_pkg;

  // ----------------------------------------------------------------
  // operation word patterns
  // ----------------------------------------------------------------
  localparam logic [9:0] OP_CALL_HI = 10'h13a; // bits 15..6 of call_subroutine
  localparam logic [9:0] OP_JUMP_HI = 10'h13b; // bits 15..6 of jump_to_target
  localparam logic [3:0] OP_LEA_TOP = 4'h4;    // bits 15..12 of load_effective_address
  localparam logic [2:0] OP_LEA_LOW = 3'h7;    // bits 8..6 of load_effective_address
  localparam logic [12:0] OP_LINKW_HI = 13'h09ca; // bits 15..3, word frame_allocate
  localparam logic [12:0] OP_LINKL_HI = 13'h0901; // bits 15..3, long frame_allocate

  // ----------------------------------------------------------------
  // addressing mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_D16 = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] SUB_ABSW = 3'h0;
  localparam logic [2:0] SUB_ABSL = 3'h1;
  localparam logic [2:0] SUB_PCD16 = 3'h2;
  localparam logic [2:0] SUB_PCIDX = 3'h3;

  // ----------------------------------------------------------------
  // fixed figures
  // ----------------------------------------------------------------
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [31:0] PUSH_BYTES = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0002;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_JUMP, K_CALL, K_LEA, K_LINK} cfao_kind_t;

  typedef struct packed {
    logic        is_areg;  // index from address registers
    logic [2:0]  reg_num;
    logic        is_long;
    logic [1:0]  scale;
    logic        full_fmt; // full extension format, not handled here
    logic [7:0]  disp8;
  } cfao_brief_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  idx;
    logic [31:0] data;
  } cfao_regwr_t;

endpackage : cfao_pkg

// File: src/cfao_areg_mem.sv
// Purpose: address register bank with one registered read port and one write port
// Assumes: write and read in one cycle to one entry return the old value
// Notes: entry 7 is the stack pointer
`timescale 1ns/1ps
module cfao_areg_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data,
  // write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data
);
  import cfao_pkg::*;

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // storage cells, cleared at reset
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_cell
      always_ff @(posedge core_clk)
      begin
        if (rst)
          mem_reg[g] <= WIDTH'(RESET_WORD);
        else if (wr_en && wr_idx == ($clog2(DEPTH))'(g))
          mem_reg[g] <= wr_data;
      end
    end
  endgenerate

  // registered read data
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rd_data <= WIDTH'(RESET_WORD);
    else
      rd_data <= mem_reg[rd_idx];
  end

endmodule : cfao_areg_mem

// File: src/cfao_exec.sv
// Purpose: decode and execute jump_to_target, call_subroutine, load_effective_address, frame_allocate
// Assumes: extension words are served by a request/valid handshake, the stack write by request/acknowledge
// Notes: only the brief index extension is handled; full format raises illegal
`timescale 1ns/1ps

// Contract
// - jump_to_target loads the effective address into the program_counter.
// - only control addressing modes are legal for the three addressing instructions.
// - modes 010, 101, 110 are indirect, displacement and indexed on address_reg.
// - mode 111 subfields 000..011: absolute short, long, pc displacement, pc indexed.
// - call_subroutine pushes the next instruction address at stack_pointer minus 4.
// - after the push, call_subroutine loads the target into the program_counter.
// - load_effective_address writes the address itself, all 32 bits.
// - load_effective_address register field picks the destination address_reg.
// - frame_allocate pushes address_reg, makes it the frame pointer, adds displacement.
// - word frame_allocate sign-extends its one extension word.
// - long frame_allocate takes high word first, then low word.
// - displacement is signed two's complement added to the stack_pointer.
// - frame_allocate register field picks the saved frame pointer register.
module cfao_exec (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // operation word from the core
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [31:0] op_pc,
  output logic op_ready,
  // extension word fetch
  output logic ext_req,
  output logic [31:0] ext_addr,
  input wire logic ext_valid,
  input wire logic [15:0] ext_data,
  // stack long-word write
  output logic mem_wr_req,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_wr_ack,
  // data registers for indexing
  input wire logic [7:0][31:0] data_regs,
  // results toward the core
  output logic pc_load,
  output logic [31:0] pc_value,
  output cfao_pkg::cfao_regwr_t areg_wr,
  output logic cc_write,
  output logic done,
  output logic illegal
);
  import cfao_pkg::*;

  typedef enum {S_IDLE, S_EXT, S_RBASE, S_RIDX, S_RSP, S_CALC, S_PUSH, S_WR1, S_WR2} cfao_state_t;

  cfao_state_t state_reg, state_next;
  cfao_kind_t kind_reg;
  logic [15:0] op_reg;
  logic [31:0] pcx_reg, base_reg, idx_reg, sp_reg, ea_reg, disp_reg;
  logic [15:0] ext0_reg, ext1_reg;
  logic [1:0] got_reg, need_reg;
  logic pushed_reg;
  logic [31:0] rd_data;

  // ----------------------------------------------------------------
  // operation word decode
  // ----------------------------------------------------------------
  wire is_call = op_word[15:6] == OP_CALL_HI;
  wire is_jump = op_word[15:6] == OP_JUMP_HI;
  wire is_lea = op_word[15:12] == OP_LEA_TOP && op_word[8:6] == OP_LEA_LOW;
  wire is_linkw = op_word[15:3] == OP_LINKW_HI;
  wire is_linkl = op_word[15:3] == OP_LINKL_HI;
  wire is_link = is_linkw || is_linkl;
  wire [2:0] in_mode = op_word[5:3];
  wire [2:0] in_sub = op_word[2:0];
  // control modes only; register and auto-update forms are refused
  function automatic logic ctrl_mode(input logic [2:0] m, input logic [2:0] r);
    ctrl_mode = m == MODE_IND || m == MODE_D16 || m == MODE_IDX || (m == MODE_EXT && r <= SUB_PCIDX);
  endfunction : ctrl_mode
  // number of extension words a control mode carries
  function automatic logic [1:0] ext_words(input logic [2:0] m, input logic [2:0] r);
    if (m == MODE_IND)
      ext_words = 2'd0;
    else if (m == MODE_EXT && r == SUB_ABSL)
      ext_words = 2'd2;
    else
      ext_words = 2'd1;
  endfunction : ext_words
  wire known = is_call || is_jump || is_lea || is_link;
  wire legal = is_link || ((is_call || is_jump || is_lea) && ctrl_mode(in_mode, in_sub));
  wire accept = state_reg == S_IDLE && op_valid && op_ready; // no second take in the cycle after a refusal
  wire [1:0] in_need = is_link ? (is_linkl ? 2'd2 : 2'd1) : ext_words(in_mode, in_sub);
  wire cfao_kind_t in_kind = is_link ? K_LINK : is_lea ? K_LEA : is_call ? K_CALL : K_JUMP;

  // ----------------------------------------------------------------
  // effective address arithmetic
  // ----------------------------------------------------------------
  wire [2:0] mode = op_reg[5:3];
  wire [2:0] sub = op_reg[2:0];
  wire cfao_brief_t brief = ext0_reg;
  wire [31:0] sx0 = {{16{ext0_reg[15]}}, ext0_reg};
  wire [31:0] sx8 = {{24{brief.disp8[7]}}, brief.disp8};
  wire [31:0] pc_ext = pcx_reg; // address of first extension word
  wire [31:0] idx_raw = brief.is_areg ? idx_reg : data_regs[brief.reg_num];
  wire [31:0] idx_sz = brief.is_long ? idx_raw : {{16{idx_raw[15]}}, idx_raw[15:0]};
  wire [31:0] idx_val = idx_sz << brief.scale;
  wire uses_idx = mode == MODE_IDX || (mode == MODE_EXT && sub == SUB_PCIDX);
  wire bad_ext = kind_reg != K_LINK && uses_idx && brief.full_fmt;
  wire [31:0] ret_addr = pcx_reg + {29'h0, need_reg, 1'b0}; // next instruction
  wire [31:0] sp_dec = sp_reg - PUSH_BYTES;
  wire [31:0] link_disp = kind_reg == K_LINK && need_reg == 2'd2 ? {ext0_reg, ext1_reg} : sx0;
  // address register and mode selection
  logic [31:0] ea_calc;
  always_comb
  begin
    ea_calc = base_reg;
    case (mode)
      MODE_IND: ea_calc = base_reg;
      MODE_D16: ea_calc = base_reg + sx0;
      MODE_IDX: ea_calc = base_reg + sx8 + idx_val;
      MODE_EXT:
        case (sub)
          SUB_ABSW: ea_calc = sx0;
          SUB_ABSL: ea_calc = {ext0_reg, ext1_reg};
          SUB_PCD16: ea_calc = pc_ext + sx0;
          default: ea_calc = pc_ext + sx8 + idx_val;
        endcase
      default: ea_calc = base_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // register bank reads and writes
  // ----------------------------------------------------------------
  wire [2:0] rd_idx = state_reg == S_RBASE ? (kind_reg == K_LINK ? op_reg[2:0] : sub) :
                      state_reg == S_RIDX ? brief.reg_num : SP_INDEX;
  wire wr_en = (state_reg == S_WR1) || (state_reg == S_WR2) || (state_reg == S_CALC && !bad_ext && kind_reg == K_LEA);
  wire [2:0] wr_idx = state_reg == S_CALC ? op_reg[11:9] : state_reg == S_WR1 ? op_reg[2:0] : SP_INDEX;
  wire [31:0] wr_data = state_reg == S_CALC ? ea_calc :
                        state_reg == S_WR1 ? (kind_reg == K_LINK ? sp_dec : ea_reg) :
                        kind_reg == K_LINK ? sp_dec + disp_reg : sp_dec;
  cfao_areg_mem #(.DEPTH(8), .WIDTH(32)) u_areg (
    .core_clk(core_clk),
    .rst(rst),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data)
  );
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire ext_take = ext_req && ext_valid;
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (accept && known && legal)
          state_next = in_need == 2'd0 ? S_RBASE : S_EXT;
      S_EXT:
        if (ext_take && got_reg + 2'd1 == need_reg)
          state_next = S_RBASE;
      S_RBASE: state_next = S_RIDX;
      S_RIDX: state_next = S_RSP;
      S_RSP: state_next = S_CALC;
      S_CALC:
        if (bad_ext)
          state_next = S_IDLE;
        else if (kind_reg == K_JUMP || kind_reg == K_LEA)
          state_next = S_IDLE;
        else
          state_next = S_PUSH;
      S_PUSH:
        if (mem_wr_ack)
          state_next = kind_reg == K_LINK ? S_WR1 : S_WR2;
      S_WR1: state_next = S_WR2;
      S_WR2: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end
  // state and working registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      kind_reg <= K_JUMP;
      op_reg <= 16'h0000;
      pcx_reg <= RESET_WORD;
      need_reg <= 2'd0;
    end
    else
    begin
      state_reg <= state_next;
      if (accept)
      begin
        kind_reg <= in_kind;
        op_reg <= op_word;
        pcx_reg <= op_pc + WORD_BYTES;
        need_reg <= in_need;
      end
    end
  end
  // extension word capture, high-order word arrives first
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      got_reg <= 2'd0;
      ext0_reg <= 16'h0000;
      ext1_reg <= 16'h0000;
      ext_req <= 1'b0;
      ext_addr <= RESET_WORD;
    end
    else if (accept)
    begin
      got_reg <= 2'd0;
      ext_req <= known && legal && in_need != 2'd0;
      ext_addr <= op_pc + WORD_BYTES;
    end
    else if (ext_take)
    begin
      got_reg <= got_reg + 2'd1;
      if (got_reg == 2'd0)
        ext0_reg <= ext_data;
      else
        ext1_reg <= ext_data;
      ext_addr <= ext_addr + WORD_BYTES;
      ext_req <= got_reg + 2'd1 != need_reg;
    end
  end
  // operand capture from the register bank
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      base_reg <= RESET_WORD;
      idx_reg <= RESET_WORD;
      sp_reg <= RESET_WORD;
      ea_reg <= RESET_WORD;
      disp_reg <= RESET_WORD;
    end
    else
    begin
      if (state_reg == S_RIDX)
        base_reg <= rd_data;
      if (state_reg == S_RSP)
        idx_reg <= rd_data;
      if (state_reg == S_CALC)
      begin
        sp_reg <= rd_data;
        ea_reg <= ea_calc;
        disp_reg <= link_disp;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  wire jump_fin = state_reg == S_CALC && !bad_ext && kind_reg == K_JUMP;
  wire call_fin = state_reg == S_WR2 && kind_reg == K_CALL;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      op_ready <= 1'b0;
      mem_wr_req <= 1'b0;
      mem_addr <= RESET_WORD;
      mem_wdata <= RESET_WORD;
      pc_load <= 1'b0;
      pc_value <= RESET_WORD;
      areg_wr <= '0;
      cc_write <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      pushed_reg <= 1'b0;
    end
    else
    begin
      op_ready <= state_next == S_IDLE && !accept;
      if (state_reg == S_CALC && state_next == S_PUSH)
      begin
        mem_wr_req <= 1'b1;
        mem_addr <= rd_data - PUSH_BYTES;
        mem_wdata <= kind_reg == K_LINK ? base_reg : ret_addr;
      end
      else if (mem_wr_ack)
        mem_wr_req <= 1'b0;
      pushed_reg <= state_reg == S_PUSH && mem_wr_ack ? 1'b1 : accept ? 1'b0 : pushed_reg;
      pc_load <= jump_fin || call_fin;
      if (jump_fin)
        pc_value <= ea_calc;
      else if (call_fin)
        pc_value <= ea_reg;
      areg_wr <= '{en: wr_en, idx: wr_idx, data: wr_data};
      cc_write <= 1'b0;
      done <= (state_reg == S_CALC && !bad_ext && state_next == S_IDLE) || state_reg == S_WR2;
      illegal <= (accept && !(known && legal)) || (state_reg == S_CALC && bad_ext);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_refuse_reg_mode: assert property (accept && (is_jump || is_call) && !is_link && in_mode == 3'h0
    |=> illegal) else $error("data register mode not refused");
  a_decode_call_op: assert property (accept && is_call && legal |=> kind_reg == K_CALL)
    else $error("call pattern misdecoded");
  a_abs_short_ea: assert property (state_reg == S_CALC && mode == MODE_EXT && sub == SUB_ABSW
    |-> ea_calc == {{16{ext0_reg[15]}}, ext0_reg}) else $error("absolute short not sign extended");
  a_d16_ea_sum: assert property (state_reg == S_CALC && mode == MODE_D16
    |-> ea_calc == base_reg + {{16{ext0_reg[15]}}, ext0_reg}) else $error("displacement address wrong");
  a_jump_pc_load: assert property (jump_fin |=> pc_load && pc_value == $past(ea_calc))
    else $error("jump target not loaded");
  a_call_push_addr: assert property ($rose(mem_wr_req) && kind_reg == K_CALL
    |-> mem_addr == sp_reg - 32'h4 && mem_wdata == ret_addr) else $error("return push wrong");
  a_call_after_push: assert property (pc_load && kind_reg == K_CALL |-> pushed_reg)
    else $error("call jumped before push");
  a_lea_dest_reg: assert property (state_reg == S_CALC && kind_reg == K_LEA && !bad_ext
    |=> areg_wr.en && areg_wr.idx == op_reg[11:9] && areg_wr.data == ea_reg) else $error("lea write wrong");
  a_link_frame_ptr: assert property (state_reg == S_WR1 |=> areg_wr.idx == op_reg[2:0]
    && areg_wr.data == sp_reg - 32'h4 ##1 areg_wr.idx == 3'h7 && areg_wr.data == sp_reg - 32'h4 + disp_reg)
    else $error("frame pointer sequence wrong");
  a_link_word_sext: assert property (state_reg == S_CALC && kind_reg == K_LINK && need_reg == 2'd1
    |=> disp_reg == {{16{ext0_reg[15]}}, ext0_reg}) else $error("word displacement not extended");
  a_link_long_order: assert property (state_reg == S_CALC && kind_reg == K_LINK && need_reg == 2'd2
    |=> disp_reg == {ext0_reg, ext1_reg}) else $error("long displacement order wrong");
  a_cc_kept: assert property (!cc_write) else $error("condition codes touched");
  c_call_done: cover property (call_fin ##1 pc_load);
  c_link_long: cover property (state_reg == S_WR2 && kind_reg == K_LINK && need_reg == 2'd2);
  c_pc_indexed: cover property (state_reg == S_CALC && mode == MODE_EXT && sub == SUB_PCIDX);
  c_illegal_op: cover property (illegal);
endmodule : cfao_exec

// File: tb/cfao_mem_model.sv
// Purpose: fetch and stack memory model on the far side of the instruction unit
// Assumes: extension words sit at consecutive half-word addresses from base
// Notes: answers after dly idle cycles; the data line toggles while not valid
`timescale 1ns/1ps
module cfao_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // setup from the bench
  input wire logic [1:0] dly,
  input wire logic [31:0] base,
  input wire logic [2:0][15:0] words,
  // extension word port
  input wire logic ext_req,
  input wire logic [31:0] ext_addr,
  output logic ext_valid,
  output logic [15:0] ext_data,
  // stack write port
  input wire logic mem_wr_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_wr_ack,
  // record of the last write
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [7:0] wr_cnt
);
  logic [1:0] wait_reg;
  logic [31:0] offs;

  // half-word index of the requested extension word
  assign offs = (ext_addr - base) >> 1;

  // answer each request after dly idle cycles, one word or one write at a time
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ext_valid <= 1'b0;
      ext_data <= 16'h0000;
      mem_wr_ack <= 1'b0;
      wait_reg <= 2'h0;
      wr_cnt <= 8'h00;
    end
    else
    begin
      ext_data <= ~ext_data; // stale data never shows as valid
      ext_valid <= 1'b0;
      mem_wr_ack <= 1'b0;
      wait_reg <= wait_reg + 2'h1;
      if ((ext_req && ext_valid) || mem_wr_ack)
        wait_reg <= 2'h0;
      else if (ext_req && wait_reg >= dly)
      begin
        ext_valid <= 1'b1;
        ext_data <= words[offs[1:0]];
      end
      else if (mem_wr_req && wait_reg >= dly)
        mem_wr_ack <= 1'b1;
      if (mem_wr_req && mem_wr_ack)
      begin
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
        wr_cnt <= wr_cnt + 8'h01;
      end
    end
  end
endmodule : cfao_mem_model

// File: tb/tb.sv
// Purpose: self-checking bench for the control-flow and address instruction unit
// Assumes: address registers start at zero and are loaded by load_effective_address
// Notes: expectations come from a shadow copy of the address registers
`timescale 1ns/1ps
module tb;
  import cfao_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk, rst, op_valid, op_ready, ext_req, ext_valid, mem_wr_req, mem_wr_ack;
  logic pc_load, cc_write, done, illegal, got_done, got_ill, cc_seen;
  logic [15:0] op_word, ext_data, lfsr, w;
  logic [31:0] op_pc, ext_addr, mem_addr, mem_wdata, pc_value, wr_addr, wr_data, base, got_pc;
  logic [7:0][31:0] data_regs;
  logic [2:0][15:0] words;
  logic [1:0] dly;
  logic [7:0] wr_cnt, c0;
  logic [5:0] e6;
  logic [31:0] am [8];
  cfao_regwr_t areg_wr;
  cfao_regwr_t wq [$];
  int errors, total_checks, n_pc, i;

  cfao_exec uut (.core_clk, .rst, .op_valid, .op_word, .op_pc, .op_ready, .ext_req, .ext_addr, .ext_valid,
    .ext_data, .mem_wr_req, .mem_addr, .mem_wdata, .mem_wr_ack, .data_regs, .pc_load, .pc_value, .areg_wr,
    .cc_write, .done, .illegal);
  cfao_mem_model far (.core_clk, .rst, .dly, .base, .words, .ext_req, .ext_addr, .ext_valid, .ext_data,
    .mem_wr_req, .mem_addr, .mem_wdata, .mem_wr_ack, .wr_addr, .wr_data, .wr_cnt);

  // 100 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  // scaled index from a brief extension word
  function automatic logic [31:0] idx_of(input logic [15:0] x);
    logic [31:0] v;
    v = x[15] ? am[x[14:12]] : data_regs[x[14:12]];
    if (!x[11])
      v = {{16{v[15]}}, v[15:0]};
    return v << x[10:9];
  endfunction : idx_of

  // expected effective address; pc-relative base is the first extension word
  function automatic logic [31:0] ea_of(input logic [5:0] ea, input logic [31:0] pc, input logic [15:0] x, y);
    logic [31:0] b;
    b = (ea[5:3] == MODE_EXT) ? pc + WORD_BYTES : am[ea[2:0]];
    if (ea[5:3] == MODE_IND)
      return b;
    if (ea[5:3] == MODE_D16 || ea == {MODE_EXT, SUB_PCD16})
      return b + {{16{x[15]}}, x};
    if (ea == {MODE_EXT, SUB_ABSW})
      return {{16{x[15]}}, x};
    if (ea == {MODE_EXT, SUB_ABSL})
      return {x, y};
    return b + {{24{x[7]}}, x[7:0]} + idx_of(x);
  endfunction : ea_of

  task automatic cmp_val(input logic [35:0] g, e, input string m);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp_val

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // offer one operation word and collect everything until done or illegal
  task automatic run(input logic [15:0] ow, input logic [31:0] pc, input logic [15:0] x, y);
    int k;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_word <= ow;
    op_pc <= pc;
    base <= pc + WORD_BYTES;
    words <= {16'h0000, y, x};
    dly <= 2'(rnd());
    wq.delete();
    n_pc = 0;
    cc_seen = 1'b0;
    c0 = wr_cnt;
    for (k = 0; k < 200; k++)
    begin
      @(negedge core_clk);
      if (op_ready === 1'b1)
        break;
    end
    if (k == 200)
    begin
      errors++;
      give_verdict();
    end
    @(posedge core_clk);
    op_valid <= 1'b0;
    for (k = 0; k < 200; k++)
    begin
      @(negedge core_clk);
      cc_seen = cc_seen | (cc_write !== 1'b0);
      if (areg_wr.en === 1'b1)
        wq.push_back(areg_wr);
      if (pc_load === 1'b1)
      begin
        n_pc++;
        got_pc = pc_value;
      end
      if (done === 1'b1 || illegal === 1'b1)
        break;
    end
    got_done = done;
    got_ill = illegal;
    if (k == 200)
    begin
      errors++;
      give_verdict();
    end
  endtask : run

  // kinds: 0 jump, 1 call, 2 lea, 3 frame_allocate (ea[3] picks the long form)
  task automatic do_kind(input int t, input logic [2:0] r, input logic [5:0] ea, input logic [31:0] pc,
    input logic [15:0] x, y);
    logic [31:0] e, sp, d;
    cfao_regwr_t eq [$];
    e = ea_of(ea, pc, x, y);
    sp = am[7] - PUSH_BYTES;
    d = ea[3] ? {x, y} : {{16{x[15]}}, x};
    case (t)
      0: run({OP_JUMP_HI, ea}, pc, x, y);
      1: run({OP_CALL_HI, ea}, pc, x, y);
      2: run({OP_LEA_TOP, r, OP_LEA_LOW, ea}, pc, x, y);
      default: run(ea[3] ? {OP_LINKL_HI, r} : {OP_LINKW_HI, r}, pc, x, y);
    endcase
    cmp_val(got_done, 1'b1, "done");
    cmp_val(cc_seen, 1'b0, "cc write");
    cmp_val(n_pc, t < 2, "pc loads");
    if (t < 2)
      cmp_val(got_pc, e, "target");
    cmp_val(8'(wr_cnt - c0), t % 2, "writes");
    if (t % 2 == 1)
      cmp_val(wr_addr, sp, "push addr");
    if (t == 1)
      cmp_val(wr_data, pc + WORD_BYTES * ((ea[5:3] == MODE_IND) ? 1 : (ea == 6'h39) ? 3 : 2), "ret");
    if (t == 3)
      cmp_val(wr_data, am[r], "saved");
    if (t == 1)
      eq.push_back('{1'b1, SP_INDEX, sp});
    if (t == 2)
      eq.push_back('{1'b1, r, e});
    if (t == 3)
    begin
      eq.push_back('{1'b1, r, sp});
      eq.push_back('{1'b1, SP_INDEX, sp + d});
    end
    cmp_val(wq.size(), eq.size(), "reg writes");
    foreach (eq[j])
    begin
      cmp_val(wq[j], eq[j], "reg write");
      am[eq[j].idx] = eq[j].data;
    end
  endtask : do_kind

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_word = 16'h0000;
    op_pc = 32'h0000_0000;
    dly = 2'h0;
    base = 32'h0000_0000;
    words = '0;
    lfsr = 16'd11872;
    errors = 0;
    total_checks = 0;
    foreach (am[j])
      am[j] = RESET_WORD;
    for (i = 0; i < 8; i++)
      data_regs[i] = {rnd(), rnd()};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    // every address register through absolute long
    for (i = 0; i < 8; i++)
      do_kind(2, 3'(i), {MODE_EXT, SUB_ABSL}, 32'h0000_1000, rnd(), rnd());
    $display("test load_regs done");
    // random mix of all four with every control mode
    for (i = 0; i < 64; i++)
    begin
      e6 = {(i % 4 == 3) ? MODE_EXT : (i % 4 == 2) ? MODE_IDX : (i % 4 == 1) ? MODE_D16 : MODE_IND, 3'(rnd())};
      if (e6[5:3] == MODE_EXT)
        e6[2] = 1'b0;
      do_kind(int'(rnd() % 4), 3'(rnd()), e6, {rnd(), rnd()} & 32'hffff_fffe, rnd() & 16'hfeff, rnd());
    end
    $display("test random done");
    // negative displacements, extreme word value, sign-extended short address
    do_kind(3, 3'h6, 6'h00, 32'h0000_2000, 16'h8000, 16'h0000);
    do_kind(3, 3'h7, 6'h08, 32'h0000_2000, 16'hffff, 16'hfff0);
    do_kind(2, 3'h3, 6'h38, 32'h0000_2000, 16'hfffe, 16'h0000);
    do_kind(1, 3'h0, 6'h3b, 32'h0000_3000, 16'h0000, 16'h0000);
    $display("test corners done");
    // non-control modes, unused mode 111 subfields, an unknown word, a full-format index word
    for (i = 0; i < 10; i++)
    begin
      e6 = (i < 4) ? {3'(i + (i > 1)), 3'(rnd())} : {MODE_EXT, 3'(i)};
      if (i == 9)
        e6 = {MODE_IDX, 3'h1};
      w = (i % 3 == 0) ? {OP_JUMP_HI, e6} : (i % 3 == 1) ? {OP_CALL_HI, e6} : {OP_LEA_TOP, 3'h2, OP_LEA_LOW, e6};
      if (i == 8)
        w = 16'hffff;
      c0 = wr_cnt;
      run(w, 32'h0000_4000, (i == 9) ? 16'h0100 : 16'h0000, 16'h0000);
      cmp_val({got_ill, got_done, 8'(n_pc), 8'(wq.size())}, 18'h20000, "refusal");
      cmp_val(wr_cnt, c0, "refused write");
    end
    $display("test illegal done");
    give_verdict();
  end
endmodule : tb
